//--- shared/flash_cfg_regs.svh
/*
 * Constants for the serial flash configuration link: command codes,
 * configuration register fields and reset values, host register offsets
 * and link timing counts.
 * Assumes inclusion by bare name from both ends and the testbench.
 */
`ifndef FLASH_CFG_REGS_SVH
`define FLASH_CFG_REGS_SVH

// ****************************************
// Command codes
// ****************************************
`define OP_READ_CFG 8'h85
`define OP_WRITE_CFG 8'h81
`define OP_FAST_READ 8'h0B
`define OP_TUNE 8'h9A

// ****************************************
// Volatile configuration register layout
// ****************************************
`define CFG_DUMMY_MSB 7
`define CFG_DUMMY_LSB 4
`define CFG_XIP_BIT 3
`define CFG_RSVD_BIT 2
`define CFG_WRAP_MSB 1
`define CFG_WRAP_LSB 0
`define CFG_RESET 8'hFB
`define CFG_WRITE_MASK 8'hFB
`define DUMMY_CODE_ALT 4'h0
`define DUMMY_CODE_DEF 4'hF
`define DUMMY_DEFAULT 5'h08
`define WRAP_16 2'h0
`define WRAP_32 2'h1
`define WRAP_64 2'h2
`define WRAP_CONT 2'h3
`define NV_DUMMY_RESET 4'hF
`define NV_XIP_N_RESET 1'h1
`define NV_WRAP_RESET 2'h3
`define TUNE_PATTERN 8'h3C

// ****************************************
// Host register offsets
// ****************************************
`define HREG_CTRL 8'h00
`define HREG_ADDR 8'h04
`define HREG_LEN 8'h08
`define HREG_DUMMY 8'h0C
`define HREG_STATUS 8'h10
`define HREG_RXDATA 8'h14

// ****************************************
// Timing
// ****************************************
`define CLK_MHZ 250
`define SCLK_MAX_STR_MHZ 133
`define SCLK_MAX_DTR_MHZ 90
`define HOST_HALF_DEFAULT 8
`define HOST_HALF_MIN 8

`endif

//--- shared/flash_cfg_pkg.sv
/*
 * Types shared by the flash device end and the host controller end.
 * Assumes flash_cfg_regs.svh is on the include path.
 */
package flash_cfg_pkg;
	typedef enum logic [2:0] {
		D_OPC = 3'h0,
		D_ADDR = 3'h1,
		D_DUMMY = 3'h2,
		D_WDATA = 3'h3,
		D_OUT = 3'h4,
		D_IGNORE = 3'h5
	} dev_state_t;
	typedef enum logic [1:0] {
		SRC_CFG = 2'h0,
		SRC_MEM = 2'h1,
		SRC_TUNE = 2'h2
	} out_src_t;
	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_TX = 3'h1,
		H_DUMMY = 3'h2,
		H_RX = 3'h3,
		H_END = 3'h4
	} host_state_t;
	typedef enum logic [1:0] {
		HOP_READ_CFG = 2'h0,
		HOP_WRITE_CFG = 2'h1,
		HOP_FAST_READ = 2'h2,
		HOP_TUNE = 2'h3
	} host_op_t;
endpackage

//--- shared/flash_link_if.sv
/*
 * Serial link between the host controller and the flash device.
 * Assumes the host drives clock, select and command data, the device
 * drives read data; the clock idles low and select idles high.
 */
interface flash_link_if;
	logic sck;
	logic cs_n;
	logic mosi;
	logic miso;
	modport device (input sck, input cs_n, input mosi, output miso);
	modport host (output sck, output cs_n, output mosi, input miso);
endinterface

//--- logic/flash_cfg_device.sv
/*
 * Device end: volatile read configuration register, internal
 * configuration copy and the read path it steers.
 * Assumes link pins are asynchronous to i_clk and that the link clock
 * half period spans at least eight i_clk cycles.
 */
// What this block does
// - 8-bit volatile register, dedicated read/write commands.
// - Either command copies register into internal config.
// - Bits 7:4 codes 1..14 give dummy clocks.
// - Code 0000 acts as 1111, command default.
// - Bit 3 low enables execute-in-place; default off.
// - Wrap 00/01/10 wraps in aligned 16/32/64 bytes.
// - Wrap 11 increments continuously through array.
// - Host picks dummy count fitting its clock.
// - Single rate clock under per-count limit.
// - Double rate clock under per-count limit.
// - Tuning pattern offered for latch point adjustment.
// - Written settings apply when write completes.
// - Reset reloads internal config from nonvolatile defaults.
`include "flash_cfg_regs.svh"
module flash_cfg_device
	import flash_cfg_pkg::*;
#(
	parameter int MEM_AW = 24
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Serial link
	flash_link_if.device link,
	// Configuration in force
	output logic [7:0] o_vcfg,
	output logic [3:0] o_dummy_code,
	output logic o_xip_disabled,
	output logic [1:0] o_wrap_mode,
	output logic o_xip_armed
);
	// The check requires at least 128 bytes, twice the 64-byte wrap, and the address holds 24 bits.
	if (MEM_AW < 7 || MEM_AW > 24) begin : g_bad_aw
		$error("MEM_AW must lie between 7 and 24");
	end

	localparam logic [23:0] ARRAY_MASK = 24'(({25'h1} << MEM_AW) - 25'h1);

	typedef struct packed {
		logic [1:0] sck_s;
		logic sck_d;
		logic [1:0] cs_s;
		logic [1:0] mosi_s;
		dev_state_t st;
		out_src_t src;
		logic [4:0] bitn;
		logic [2:0] obit;
		logic [7:0] sh;
		logic [7:0] obyte;
		logic [23:0] addr;
		logic [7:0] vreg;
		logic [3:0] int_dummy;
		logic int_xip_n;
		logic [1:0] int_wrap;
		logic xip_armed;
		logic miso;
	} dev_reg_t;

	dev_reg_t r;
	dev_reg_t n;
	logic rise;
	logic fall;
	logic bit_in;
	logic [7:0] sh_in;
	logic [4:0] eff_dummy;

	// ****************************************
	// Read path helpers
	// ****************************************
	// Stand-in array contents: a byte derived from its own address.
	function automatic logic [7:0] mem_byte(input logic [23:0] a);
		logic [23:0] m;
		m = a & ARRAY_MASK;
		return m[7:0] ^ m[15:8] ^ m[23:16];
	endfunction

	function automatic logic [23:0] next_addr(input logic [23:0] a, input logic [1:0] wrap);
		logic [23:0] m;
		logic [23:0] inc;
		inc = a + 24'h000001;
		case (wrap)
			`WRAP_16: m = 24'h00000F;
			`WRAP_32: m = 24'h00001F;
			`WRAP_64: m = 24'h00003F;
			default: m = 24'h000000;
		endcase
		if (m == 24'h000000) begin
			return inc & ARRAY_MASK;
		end
		return (a & ~m) | (inc & m);
	endfunction

	assign rise = r.sck_s[1] & ~r.sck_d;
	assign fall = ~r.sck_s[1] & r.sck_d;
	assign bit_in = r.mosi_s[1];
	assign sh_in = {r.sh[6:0], bit_in};

	assign eff_dummy = (r.int_dummy == `DUMMY_CODE_ALT || r.int_dummy == `DUMMY_CODE_DEF) ?
		`DUMMY_DEFAULT : {1'b0, r.int_dummy};

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		n = r;
		n.sck_s = {r.sck_s[0], link.sck};
		n.sck_d = r.sck_s[1];
		n.cs_s = {r.cs_s[0], link.cs_n};
		n.mosi_s = {r.mosi_s[0], link.mosi};
		if (r.cs_s[1]) begin
			n.st = r.xip_armed ? D_ADDR : D_OPC;
			n.bitn = 5'h00;
			n.obit = 3'h0;
			n.miso = 1'b0;
		end else if (rise) begin
			n.bitn = r.bitn + 5'h01;
			n.sh = sh_in;
			case (r.st)
				D_OPC: begin
					if (r.bitn == 5'h07) begin
						n.bitn = 5'h00;
						case (sh_in)
							`OP_READ_CFG: begin
								n.st = D_OUT;
								n.src = SRC_CFG;
								n.obyte = r.vreg & `CFG_WRITE_MASK;
								n.int_dummy = r.vreg[`CFG_DUMMY_MSB:`CFG_DUMMY_LSB];
								n.int_xip_n = r.vreg[`CFG_XIP_BIT];
								n.int_wrap = r.vreg[`CFG_WRAP_MSB:`CFG_WRAP_LSB];
							end
							`OP_WRITE_CFG: begin
								n.st = D_WDATA;
							end
							`OP_FAST_READ: begin
								n.st = D_ADDR;
							end
							`OP_TUNE: begin
								n.st = D_OUT;
								n.src = SRC_TUNE;
								n.addr = 24'h000000;
								n.obyte = `TUNE_PATTERN;
							end
							default: begin
								n.st = D_IGNORE;
							end
						endcase
					end
				end
				D_ADDR: begin
					n.addr = {r.addr[22:0], bit_in};
					if (r.bitn == 5'h17) begin
						n.st = D_DUMMY;
						n.bitn = 5'h00;
					end
				end
				D_DUMMY: begin
					if (r.bitn == 5'h00) begin
						n.xip_armed = ~r.int_xip_n & ~bit_in;
					end
					if (r.bitn == eff_dummy - 5'h01) begin
						n.st = D_OUT;
						n.src = SRC_MEM;
						n.obyte = mem_byte(r.addr);
						n.bitn = 5'h00;
					end
				end
				D_WDATA: begin
					if (r.bitn == 5'h07) begin
						n.vreg = sh_in & `CFG_WRITE_MASK;
						n.int_dummy = sh_in[`CFG_DUMMY_MSB:`CFG_DUMMY_LSB];
						n.int_xip_n = sh_in[`CFG_XIP_BIT];
						n.int_wrap = sh_in[`CFG_WRAP_MSB:`CFG_WRAP_LSB];
						n.st = D_IGNORE;
					end
				end
				default: begin
					n.bitn = r.bitn;
				end
			endcase
		end else if (fall && r.st == D_OUT) begin
			n.miso = r.obyte[7];
			n.obyte = {r.obyte[6:0], 1'b0};
			n.obit = r.obit + 3'h1;
			if (r.obit == 3'h7) begin
				case (r.src)
					SRC_MEM: begin
						n.addr = next_addr(r.addr, r.int_wrap);
						n.obyte = mem_byte(next_addr(r.addr, r.int_wrap));
					end
					SRC_TUNE: begin
						n.addr = r.addr + 24'h000001;
						n.obyte = r.addr[0] ? `TUNE_PATTERN : ~`TUNE_PATTERN;
					end
					default: begin
						n.obyte = r.vreg & `CFG_WRITE_MASK;
					end
				endcase
			end
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			r <= '0;
			r.cs_s <= 2'h3;
			r.st <= D_OPC;
			r.src <= SRC_CFG;
			r.vreg <= `CFG_RESET;
			r.int_dummy <= `NV_DUMMY_RESET;
			r.int_xip_n <= `NV_XIP_N_RESET;
			r.int_wrap <= `NV_WRAP_RESET;
		end else begin
			r <= n;
		end
	end

	assign link.miso = r.miso;
	assign o_vcfg = r.vreg;
	assign o_dummy_code = r.int_dummy;
	assign o_xip_disabled = r.int_xip_n;
	assign o_wrap_mode = r.int_wrap;
	assign o_xip_armed = r.xip_armed;
endmodule

//--- logic/flash_cfg_host.sv
/*
 * Host end: receive FIFO and the controller that issues configuration,
 * fast read and tuning commands on the serial link.
 * Assumes software reaches it through the plain register port and
 * programs a dummy count that matches the device setting.
 */
`include "flash_cfg_regs.svh"
module flash_rx_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Write side
	input wire logic i_in_valid,
	input wire logic [W-1:0] i_in_data,
	output logic o_in_ready,
	// Read side
	output logic o_out_valid,
	output logic [W-1:0] o_out_data,
	input wire logic i_out_ready
);
	localparam int AW = $clog2(D);
	// The pointers wrap by overflow, so the depth must be a power of two.
	if (D < 2 || (1 << AW) != D) begin : g_bad_depth
		$error("FIFO depth must be a power of two");
	end
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0] cnt;
	logic push;
	logic pop;

	assign o_in_ready = cnt != (AW + 1)'(D);
	assign o_out_valid = cnt != '0;
	assign o_out_data = mem[rp];
	assign push = i_in_valid & o_in_ready;
	assign pop = i_out_ready & o_out_valid;

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wp] <= i_in_data;
		end
	end
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
		end else begin
			wp <= wp + AW'(push);
			rp <= rp + AW'(pop);
			cnt <= cnt + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end
endmodule

module flash_cfg_host
	import flash_cfg_pkg::*;
#(
	parameter int HALF = `HOST_HALF_DEFAULT
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_we,
	input wire logic i_re,
	output logic [31:0] o_rdata,
	// Serial link
	flash_link_if.host link
);
	// sampling, single rate and double rate clock limits
	// Holding the double rate limit too keeps the divider safe for either rate.
	if (HALF < `HOST_HALF_MIN || `CLK_MHZ > 2 * HALF * `SCLK_MAX_STR_MHZ ||
		`CLK_MHZ > 2 * HALF * `SCLK_MAX_DTR_MHZ) begin : g_bad_half
		$error("HALF too small for sampling or clock limit");
	end

	typedef struct packed {
		host_state_t st;
		host_op_t op;
		logic [7:0] div;
		logic sck;
		logic cs_n;
		logic mosi;
		logic [31:0] txsh;
		logic [5:0] nbits;
		logic [15:0] bytes;
		logic [7:0] rxsh;
		logic [2:0] rxcnt;
		logic push_v;
		logic [23:0] addr;
		logic [15:0] len;
		logic [3:0] dummy;
		logic keep;
		logic xip_armed;
		logic [1:0] miso_s;
		logic [31:0] rdata;
	} host_reg_t;

	host_reg_t r;
	host_reg_t n;
	logic in_ready;
	logic out_valid;
	logic [7:0] out_data;
	logic pop;
	logic stall;
	logic tick;

	flash_rx_fifo #(.W(8), .D(16)) u_fifo (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_in_valid(r.push_v),
		.i_in_data(r.rxsh),
		.o_in_ready(in_ready),
		.o_out_valid(out_valid),
		.o_out_data(out_data),
		.i_out_ready(pop)
	);

	assign pop = i_re && i_addr == `HREG_RXDATA && out_valid;
	// A full FIFO holds the link clock still until software drains it.
	assign stall = r.push_v & ~in_ready;
	assign tick = r.div == 8'(HALF - 1);

	always_comb begin
		n = r;
		n.miso_s = {r.miso_s[0], link.miso};
		n.push_v = r.push_v & ~in_ready;
		n.rdata = 32'h00000000;
		if (i_re) begin
			case (i_addr)
				`HREG_ADDR: n.rdata = {8'h00, r.addr};
				`HREG_LEN: n.rdata = {16'h0000, r.len};
				`HREG_DUMMY: n.rdata = {28'h0000000, r.dummy};
				`HREG_STATUS: n.rdata = {29'h00000000, r.xip_armed, out_valid, r.st != H_IDLE};
				`HREG_RXDATA: n.rdata = {24'h000000, out_valid ? out_data : 8'h00};
				default: n.rdata = 32'h00000000;
			endcase
		end
		if (i_we) begin
			case (i_addr)
				`HREG_ADDR: n.addr = i_wdata[23:0];
				`HREG_LEN: n.len = i_wdata[15:0];
				`HREG_DUMMY: n.dummy = i_wdata[3:0];
				`HREG_CTRL: begin
					if (r.st == H_IDLE) begin
						n.op = host_op_t'(i_wdata[1:0]);
						n.keep = i_wdata[16];
						n.st = H_TX;
						n.cs_n = 1'b0;
						n.div = 8'h00;
						n.rxcnt = 3'h0;
						n.bytes = r.len;
						case (host_op_t'(i_wdata[1:0]))
							HOP_READ_CFG: begin
								n.txsh = {`OP_READ_CFG, 24'h000000};
								n.nbits = 6'd8;
								n.bytes = 16'h0001;
							end
							HOP_WRITE_CFG: begin
								n.txsh = {`OP_WRITE_CFG, i_wdata[15:8], 16'h0000};
								n.nbits = 6'd16;
							end
							HOP_FAST_READ: begin
								n.txsh = r.xip_armed ? {r.addr, 8'h00} : {`OP_FAST_READ, r.addr};
								n.nbits = r.xip_armed ? 6'd24 : 6'd32;
							end
							default: begin
								n.txsh = {`OP_TUNE, 24'h000000};
								n.nbits = 6'd8;
							end
						endcase
						n.mosi = n.txsh[31];
						n.txsh = {n.txsh[30:0], 1'b0};
					end
				end
				default: begin
					n.keep = r.keep;
				end
			endcase
		end
		if (r.st != H_IDLE && !stall) begin
			n.div = tick ? 8'h00 : r.div + 8'h01;
			if (tick && r.st == H_END) begin
				n.st = H_IDLE;
			end else if (tick && !r.sck) begin
				n.sck = 1'b1;
				if (r.st == H_RX) begin
					n.rxsh = {r.rxsh[6:0], r.miso_s[1]};
					n.rxcnt = r.rxcnt + 3'h1;
					if (r.rxcnt == 3'h7) begin
						n.push_v = 1'b1;
						n.bytes = r.bytes - 16'h0001;
					end
				end
			end else if (tick) begin
				n.sck = 1'b0;
				n.nbits = r.nbits - 6'd1;
				n.mosi = 1'b0;
				case (r.st)
					H_TX: begin
						if (r.nbits != 6'd1) begin
							n.mosi = r.txsh[31];
							n.txsh = {r.txsh[30:0], 1'b0};
						end else if (r.op == HOP_FAST_READ && r.dummy != 4'h0) begin
							n.st = H_DUMMY;
							n.nbits = {2'b00, r.dummy};
							n.mosi = ~r.keep;
							n.xip_armed = r.keep;
						end else if (r.op == HOP_WRITE_CFG || r.bytes == 16'h0000) begin
							n.st = H_END;
							n.cs_n = 1'b1;
						end else begin
							n.st = H_RX;
						end
					end
					H_DUMMY: begin
						if (r.nbits == 6'd1) begin
							n.st = r.bytes == 16'h0000 ? H_END : H_RX;
							n.cs_n = r.bytes == 16'h0000;
						end
					end
					default: begin
						if (r.bytes == 16'h0000) begin
							n.st = H_END;
							n.cs_n = 1'b1;
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			r <= '0;
			r.st <= H_IDLE;
			r.op <= HOP_READ_CFG;
			r.cs_n <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign o_rdata = r.rdata;
	assign link.sck = r.sck;
	assign link.cs_n = r.cs_n;
	assign link.mosi = r.mosi;
endmodule

//--- dv/flash_link_asserts.sv
/*
 * Checker of the serial link between the host end and the device end.
 * Assumes it sits beside the one link that joins the two design ends.
 */
module flash_link_asserts #(
	parameter int HALF = 8
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Link signals
	input wire logic i_sck,
	input wire logic i_cs_n,
	input wire logic i_mosi,
	input wire logic i_miso
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int FIRST_EDGE_MAX = 3 * HALF;
	// ****************************************
	// Link framing and timing
	// ****************************************
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);
	sequence frame_open_s;
		$fell(i_cs_n);
	endsequence
	sequence high_phase_s;
		i_sck [*8];
	endsequence
	sequence low_phase_s;
		!i_sck [*8];
	endsequence
	idle_clock_low_a: assert property (i_cs_n |-> !i_sck)
		else $error("link clock high while deselected");
	clock_high_span_a: assert property ($rose(i_sck) |-> high_phase_s)
		else $error("link clock high phase too short");
	clock_low_span_a: assert property ($fell(i_sck) |-> low_phase_s)
		else $error("link clock low phase too short");
	command_bit_hold_a: assert property (i_sck |-> $stable(i_mosi))
		else $error("command data moved while clock high");
	reply_bit_hold_a: assert property ($changed(i_miso) |-> !i_sck)
		else $error("reply data moved while clock high");
	select_gap_a: assert property ($rose(i_cs_n) |-> i_cs_n [*8])
		else $error("deselect gap too short");
	first_edge_a: assert property (frame_open_s |-> !i_sck ##[1:FIRST_EDGE_MAX] $rose(i_sck))
		else $error("no first clock edge after select");
	select_held_a: assert property ($rose(i_sck) |-> !i_cs_n [*8])
		else $error("select dropped during clock high");
endmodule

//--- dv/flash_read_config_register_tb.sv
/*
 * Testbench joining the host end and the device end over one link.
 * Assumes both ends and the link checker are compiled before it.
 */
`include "flash_cfg_regs.svh"
module flash_read_config_register_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_clk;
	logic i_resetn;
	logic [7:0] i_addr;
	logic [31:0] i_wdata;
	logic i_we;
	logic i_re;
	logic [31:0] o_rdata;
	logic [7:0] o_vcfg;
	logic [3:0] o_dummy_code;
	logic o_xip_disabled;
	logic [1:0] o_wrap_mode;
	logic o_xip_armed;
	int miscompares = 0;
	int checks = 0;
	flash_link_if lk();
	flash_cfg_host i_flash_cfg_host (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_we(i_we), .i_re(i_re), .o_rdata(o_rdata), .link(lk));
	flash_cfg_device i_flash_cfg_device (.i_clk(i_clk), .i_resetn(i_resetn), .link(lk), .o_vcfg(o_vcfg),
		.o_dummy_code(o_dummy_code), .o_xip_disabled(o_xip_disabled), .o_wrap_mode(o_wrap_mode),
		.o_xip_armed(o_xip_armed));
	flash_link_asserts #(.HALF(`HOST_HALF_DEFAULT)) i_flash_link_asserts (.i_clk(i_clk), .i_resetn(i_resetn),
		.i_sck(lk.sck), .i_cs_n(lk.cs_n), .i_mosi(lk.mosi), .i_miso(lk.miso));
	// ****************************************
	// Bus and checking tasks
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_we <= 1'h1;
		@(posedge i_clk);
		i_we <= 1'h0;
		@(posedge i_clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		i_addr <= a;
		i_re <= 1'h1;
		@(posedge i_clk);
		i_re <= 1'h0;
		#1 d = o_rdata;
		@(posedge i_clk);
	endtask
	task automatic wait_idle();
		logic [31:0] s;
		s = 32'h1;
		for (int n = 0; n < 20000 && s[0] !== 1'h0; n++) rd(`HREG_STATUS, s);
		chk(s & 32'h1, 32'h0);
	endtask
	task automatic pop(output logic [31:0] d);
		logic [31:0] s;
		s = 32'h0;
		for (int n = 0; n < 20000 && s[1] !== 1'h1; n++) rd(`HREG_STATUS, s);
		rd(`HREG_RXDATA, d);
	endtask
	function automatic logic [31:0] cfg_view();
		return {16'h0, o_vcfg, o_dummy_code, o_xip_disabled, o_wrap_mode, o_xip_armed};
	endfunction
	task automatic t_reset();
		i_resetn <= 1'h0;
		repeat (3) @(posedge i_clk);
		i_resetn <= 1'h1;
		@(posedge i_clk);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_defaults();
		logic [31:0] d;
		chk(cfg_view(), {16'h0, 8'hFB, 4'hF, 1'h1, 2'h3, 1'h0});
		wr(`HREG_CTRL, 32'h0);
		wait_idle();
		pop(d);
		chk(d, 32'hFB);
		rd(8'hFC, d);
		chk(d, 32'h0);
		$display("test defaults done");
	endtask
	task automatic t_write(input logic [7:0] v);
		logic [31:0] d;
		logic [7:0] e;
		e = v & 8'hFB;
		wr(`HREG_CTRL, {16'h0, v, 8'h01});
		wait_idle();
		chk(cfg_view(), {16'h0, e, e[7:4], e[3], e[1:0], 1'h0});
		wr(`HREG_CTRL, 32'h0);
		wait_idle();
		pop(d);
		chk(d, {24'h0, e});
		$display("test write %h done", v);
	endtask
	task automatic t_read(input logic [7:0] cfg, input logic [23:0] a, input logic [15:0] n, input logic keep);
		logic [31:0] d;
		logic [31:0] dc;
		logic [23:0] sz;
		sz = 24'h10 << cfg[1:0];
		dc = {28'h0, cfg[7:4]};
		if (cfg[7:4] == 4'h0 || cfg[7:4] == 4'hF) dc = 32'h8;
		wr(`HREG_ADDR, {8'h0, a});
		wr(`HREG_LEN, {16'h0, n});
		wr(`HREG_DUMMY, dc);
		wr(`HREG_CTRL, {15'h0, keep, 16'h2});
		for (int i = 0; i < n; i++) begin
			pop(d);
			chk(d, {24'h0, a[7:0] ^ a[15:8] ^ a[23:16]});
			a = (cfg[1:0] == 2'h3) ? a + 24'h1 : (a & ~(sz - 24'h1)) | ((a + 24'h1) & (sz - 24'h1));
		end
		wait_idle();
		chk({31'h0, o_xip_armed}, {31'h0, keep & ~cfg[3]});
		$display("test read %h done", cfg);
	endtask
	task automatic t_tune();
		logic [31:0] d;
		wr(`HREG_LEN, 32'h4);
		wr(`HREG_CTRL, 32'h3);
		for (int i = 0; i < 4; i++) begin
			pop(d);
			chk(d, i[0] ? 32'hC3 : 32'h3C);
		end
		wait_idle();
		$display("test tuning done");
	endtask
	initial begin
		i_clk = 1'h0;
		forever #2 i_clk = ~i_clk;
	end
	initial begin
		#200000;
		miscompares++;
		complete_run();
	end
	initial begin
		i_resetn = 1'h0;
		i_addr = 8'h0;
		i_wdata = 32'h0;
		i_we = 1'h0;
		i_re = 1'h0;
		t_reset();
		t_defaults();
		for (int c = 0; c < 16; c++) t_write({c[3:0], c[0], 1'h1, c[1:0]});
		t_write(8'h0C);
		t_read(8'h08, 24'h12340E, 16'h14, 1'h0);
		t_write(8'h1D);
		t_read(8'h19, 24'h00AB3E, 16'h5, 1'h0);
		t_write(8'hEE);
		t_read(8'hEA, 24'h5A5A7F, 16'h4, 1'h0);
		t_write(8'hFF);
		t_read(8'hFB, 24'hFFFFFE, 16'h4, 1'h0);
		t_tune();
		t_write(8'h53);
		t_read(8'h53, 24'h000100, 16'h3, 1'h1);
		t_read(8'h53, 24'h000200, 16'h3, 1'h0);
		t_write(8'h57);
		t_reset();
		t_defaults();
		complete_run();
	end
endmodule
